// >>> logic/bringup_pkg.sv
`default_nettype none
package bringup_pkg;
    // Register byte offsets on the AXI4-Lite slave.
    localparam logic [7:0] OFFS_CONTROL   = 8'h00;
    localparam logic [7:0] OFFS_ROLE      = 8'h04;
    localparam logic [7:0] OFFS_FWD_ADDR  = 8'h08;
    localparam logic [7:0] OFFS_REV_ADDR  = 8'h0c;
    localparam logic [7:0] OFFS_STATUS    = 8'h10;
    localparam int         AXI_ADDR_W     = 8;

    // Field positions.
    localparam int CTL_DIR_SEL_BIT   = 0;
    localparam int CTL_ADDR_WR_BIT   = 1;
    localparam int ROLE_STACK_BIT    = 0;
    localparam int ROLE_TOP_BIT      = 1;
    localparam int STAT_IS_STACK_BIT = 0;
    localparam int STAT_BUSY_BIT     = 1;
    localparam int STAT_MODE_LSB     = 2;
    localparam int ADDR_W            = 6;

    // Reset values and AXI response codes.
    localparam logic [ADDR_W-1:0] ADDR_RESET = 6'h00;
    localparam logic [1:0]        RESP_OKAY   = 2'h0;
    localparam logic [1:0]        RESP_SLVERR = 2'h2;

    // Port reconfiguration time after a direction change.
    localparam int CLK_PERIOD_NS      = 20;
    localparam int RECONFIG_TIME_NS   = 100000;
    localparam int RECONFIG_CYCLES_DFLT = (RECONFIG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {MODE_POWERED_OFF, MODE_ACTIVE, MODE_ADDRESSED, MODE_CONFIGURED} mode_e;

    typedef enum logic [2:0] {CMD_BCAST_WR, CMD_BCAST_RD, CMD_SINGLE_WR, CMD_SINGLE_RD,
                              CMD_STACK_WR, CMD_STACK_RD} cmd_e;

    typedef struct packed {
        cmd_e              kind;
        logic [ADDR_W-1:0] target;
        logic              addrField;
        logic [ADDR_W-1:0] data;
    } cmd_s;

    typedef struct packed {
        logic upperTx;
        logic upperRx;
        logic lowerTx;
        logic lowerRx;
    } chain_port_s;
endpackage : bringup_pkg
`default_nettype wire

// >>> logic/pin_sync3.sv
`timescale 1ns/100ps
`default_nettype none
module pin_sync3 #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Asynchronous pins
    input  wire logic [WIDTH-1:0] pinIn,
    // Filtered results
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise
);
    logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, level_reg, rise_reg;
    logic [WIDTH-1:0] level_next, rise_next;

    if (WIDTH < 1)
    begin : g_chk
        $error("pin_sync3 needs WIDTH of at least one");
    end

    // A change is only taken once the second and third stages agree.
    always_comb
    begin
        level_next = level_reg;
        rise_next  = '0;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (s2_reg[i] == s3_reg[i])
            begin
                level_next[i] = s3_reg[i];
            end
            rise_next[i] = level_next[i] & ~level_reg[i];
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s1_reg    <= '0;
            s2_reg    <= '0;
            s3_reg    <= '0;
            level_reg <= '0;
            rise_reg  <= '0;
        end
        else
        begin
            s1_reg    <= pinIn;
            s2_reg    <= s1_reg;
            s3_reg    <= s2_reg;
            level_reg <= level_next;
            rise_reg  <= rise_next;
        end
    end

    assign level = level_reg;
    assign rise  = rise_reg;
endmodule : pin_sync3
`default_nettype wire

// >>> logic/chain_bringup.sv
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module chain_bringup
    import bringup_pkg::*;
#(
    parameter int unsigned RECONFIG_CYCLES = RECONFIG_CYCLES_DFLT
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // AXI4-Lite register slave
    input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // Wake pins and power request
    input  wire logic                  wakePingPin,
    input  wire logic                  wakeToneUpperPin,
    input  wire logic                  wakeToneLowerPin,
    input  wire logic                  shutdownReq,
    // Decoded command frames
    input  wire logic                  frameValid,
    input  wire cmd_s                  frame,
    output logic                       frameServe,
    output logic                       frameForward,
    // Chain port enables
    output chain_port_s                chainPorts
);
    localparam int CNT_W = $clog2(RECONFIG_CYCLES + 1);

    if (RECONFIG_CYCLES < 1)
    begin : g_chk
        $error("RECONFIG_CYCLES must be at least one");
    end

    logic [2:0] wakeRise;
    logic       pingRise, toneRise;

    pin_sync3 #(.WIDTH(3)) u_wake_sync (
        .clk   (clk),
        .rst   (rst),
        .pinIn ({wakeToneLowerPin, wakeToneUpperPin, wakePingPin}),
        .level (),
        .rise  (wakeRise)
    );
    assign pingRise = wakeRise[0];
    assign toneRise = wakeRise[1] | wakeRise[2];

    mode_e             mode_reg, mode_next;
    logic              isStack_reg, isStack_next;
    logic              dirSel_reg, dirSel_next, addrWr_reg, addrWr_next;
    logic              stackRole_reg, stackRole_next, topRole_reg, topRole_next;
    logic [ADDR_W-1:0] fwdAddr_reg, fwdAddr_next, revAddr_reg, revAddr_next, ownAddr;
    logic [CNT_W-1:0]  cnt_reg, cnt_next;
    chain_port_s       ports_reg, ports_next;
    logic              serve_reg, serve_next, fwd_reg, fwd_next;
    logic              awPend_reg, awPend_next, wPend_reg, wPend_next, bvalid_reg, bvalid_next;
    logic              rvalid_reg, rvalid_next;
    logic [1:0]        bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [AXI_ADDR_W-1:0] awAddr_reg, awAddr_next;
    logic [31:0]       wData_reg, wData_next, rdata_reg, rdata_next;
    logic [3:0]        wStrb_reg, wStrb_next;
    logic              wrFire, ctlWrite, autoFrame, accept, outTxOn;

    assign ownAddr  = dirSel_reg ? revAddr_reg : fwdAddr_reg;
    assign wrFire   = awPend_reg && wPend_reg && !bvalid_reg;
    assign ctlWrite = wrFire && wStrb_reg[0] && awAddr_reg == OFFS_CONTROL;
    assign outTxOn  = dirSel_reg ? ports_reg.lowerTx : ports_reg.upperTx;
    assign autoFrame = frameValid && addrWr_reg && mode_reg != MODE_POWERED_OFF;

    // Which commands the current bring-up stage serves.
    always_comb
    begin
        accept = 1'b0;
        case (frame.kind)
            CMD_BCAST_WR: accept = mode_reg != MODE_POWERED_OFF;
            CMD_BCAST_RD: accept = mode_reg == MODE_ADDRESSED || mode_reg == MODE_CONFIGURED;
            CMD_SINGLE_WR,
            CMD_SINGLE_RD: accept = (mode_reg == MODE_ADDRESSED || mode_reg == MODE_CONFIGURED)
                                    && frame.target == ownAddr;
            CMD_STACK_WR,
            CMD_STACK_RD: accept = mode_reg == MODE_CONFIGURED && stackRole_reg;
            default:      accept = 1'b0;
        endcase
    end

    always_comb
    begin
        mode_next      = mode_reg;
        isStack_next   = isStack_reg;
        dirSel_next    = dirSel_reg;
        addrWr_next    = addrWr_reg;
        stackRole_next = stackRole_reg;
        topRole_next   = topRole_reg;
        fwdAddr_next   = fwdAddr_reg;
        revAddr_next   = revAddr_reg;
        cnt_next       = (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
        serve_next     = 1'b0;
        fwd_next       = 1'b0;
        if (shutdownReq)
        begin
            mode_next = MODE_POWERED_OFF;
        end
        // The base/stack flag is never cleared by powered_off_mode, only rewritten by a wake.
        if (pingRise)
        begin
            isStack_next = 1'b0;
            mode_next    = MODE_ACTIVE;
            addrWr_next  = 1'b0;
        end
        else if (toneRise)
        begin
            isStack_next = 1'b1;
            mode_next    = MODE_ACTIVE;
            addrWr_next  = 1'b0;
        end
        else if (autoFrame)
        begin
            // The consumed frame is never relayed, so the next device waits for its own.
            if (frame.addrField)
            begin
                if (dirSel_reg)
                begin
                    revAddr_next = frame.data;
                end
                else
                begin
                    fwdAddr_next = frame.data;
                end
            end
            addrWr_next = 1'b0;
            serve_next  = 1'b1;
            if (mode_reg == MODE_ACTIVE)
            begin
                mode_next = MODE_ADDRESSED;
            end
        end
        else if (frameValid && mode_reg != MODE_POWERED_OFF)
        begin
            serve_next = accept;
            fwd_next   = outTxOn;
            if (accept && frame.addrField && (frame.kind == CMD_BCAST_WR || frame.kind == CMD_SINGLE_WR))
            begin
                if (dirSel_reg)
                begin
                    revAddr_next = frame.data;
                end
                else
                begin
                    fwdAddr_next = frame.data;
                end
            end
        end
        // Software writes land last, so a set of the enable beats the frame clearing it.
        if (wrFire && wStrb_reg[0])
        begin
            case (awAddr_reg)
                OFFS_CONTROL:
                begin
                    dirSel_next = wData_reg[CTL_DIR_SEL_BIT];
                    addrWr_next = wData_reg[CTL_ADDR_WR_BIT];
                end
                OFFS_ROLE:
                begin
                    stackRole_next = wData_reg[ROLE_STACK_BIT];
                    topRole_next   = wData_reg[ROLE_TOP_BIT];
                    if (mode_reg == MODE_ADDRESSED)
                    begin
                        mode_next = MODE_CONFIGURED;
                    end
                end
                OFFS_FWD_ADDR: fwdAddr_next = wData_reg[ADDR_W-1:0];
                OFFS_REV_ADDR: revAddr_next = wData_reg[ADDR_W-1:0];
                default: ;
            endcase
        end
        if (dirSel_next != dirSel_reg)
        begin
            cnt_next = CNT_W'(RECONFIG_CYCLES);
        end
        // Port enables follow position, direction, role and the one-frame suppression.
        ports_next = '0;
        if (mode_reg != MODE_POWERED_OFF && cnt_reg == '0)
        begin
            if (!isStack_reg)
            begin
                ports_next.upperTx = !dirSel_reg;
                ports_next.upperRx = !dirSel_reg;
                ports_next.lowerTx = dirSel_reg;
                ports_next.lowerRx = dirSel_reg;
            end
            else
            begin
                ports_next = '{upperTx: 1'b1, upperRx: 1'b1, lowerTx: 1'b1, lowerRx: 1'b1};
            end
            // A lone base is also the top of its chain, so the role is honoured at either position.
            if (topRole_reg)
            begin
                if (dirSel_reg)
                begin
                    ports_next.lowerTx = 1'b0;
                end
                else
                begin
                    ports_next.upperTx = 1'b0;
                end
            end
            if (addrWr_next)
            begin
                if (dirSel_reg)
                begin
                    ports_next.lowerTx = 1'b0;
                end
                else
                begin
                    ports_next.upperTx = 1'b0;
                end
            end
        end
    end

    // Register slave: address and data are caught separately, answered once both are in.
    always_comb
    begin
        awPend_next = awPend_reg;
        awAddr_next = awAddr_reg;
        wPend_next  = wPend_reg;
        wData_next  = wData_reg;
        wStrb_next  = wStrb_reg;
        bvalid_next = bvalid_reg && !s_axi_bready;
        bresp_next  = bresp_reg;
        rvalid_next = rvalid_reg && !s_axi_rready;
        rresp_next  = rresp_reg;
        rdata_next  = rdata_reg;
        if (s_axi_awvalid && !awPend_reg)
        begin
            awPend_next = 1'b1;
            awAddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && !wPend_reg)
        begin
            wPend_next = 1'b1;
            wData_next = s_axi_wdata;
            wStrb_next = s_axi_wstrb;
        end
        if (wrFire)
        begin
            awPend_next = 1'b0;
            wPend_next  = 1'b0;
            bvalid_next = 1'b1;
            bresp_next  = (awAddr_reg <= OFFS_REV_ADDR && awAddr_reg[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_axi_arvalid && !rvalid_reg)
        begin
            rvalid_next = 1'b1;
            rresp_next  = RESP_OKAY;
            case (s_axi_araddr)
                OFFS_CONTROL:  rdata_next = {30'h0, addrWr_reg, dirSel_reg};
                OFFS_ROLE:     rdata_next = {30'h0, topRole_reg, stackRole_reg};
                OFFS_FWD_ADDR: rdata_next = {26'h0, fwdAddr_reg};
                OFFS_REV_ADDR: rdata_next = {26'h0, revAddr_reg};
                OFFS_STATUS:   rdata_next = {28'h0, mode_reg, cnt_reg != '0, isStack_reg};
                default:
                begin
                    rdata_next = 32'h0;
                    rresp_next = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mode_reg      <= MODE_POWERED_OFF;
            isStack_reg   <= 1'b0;
            dirSel_reg    <= 1'b0;
            addrWr_reg    <= 1'b0;
            stackRole_reg <= 1'b0;
            topRole_reg   <= 1'b0;
            fwdAddr_reg   <= ADDR_RESET;
            revAddr_reg   <= ADDR_RESET;
            cnt_reg       <= '0;
            ports_reg     <= '0;
            serve_reg     <= 1'b0;
            fwd_reg       <= 1'b0;
            awPend_reg    <= 1'b0;
            awAddr_reg    <= '0;
            wPend_reg     <= 1'b0;
            wData_reg     <= 32'h0;
            wStrb_reg     <= 4'h0;
            bvalid_reg    <= 1'b0;
            bresp_reg     <= RESP_OKAY;
            rvalid_reg    <= 1'b0;
            rresp_reg     <= RESP_OKAY;
            rdata_reg     <= 32'h0;
        end
        else
        begin
            mode_reg      <= mode_next;
            isStack_reg   <= isStack_next;
            dirSel_reg    <= dirSel_next;
            addrWr_reg    <= addrWr_next;
            stackRole_reg <= stackRole_next;
            topRole_reg   <= topRole_next;
            fwdAddr_reg   <= fwdAddr_next;
            revAddr_reg   <= revAddr_next;
            cnt_reg       <= cnt_next;
            ports_reg     <= ports_next;
            serve_reg     <= serve_next;
            fwd_reg       <= fwd_next;
            awPend_reg    <= awPend_next;
            awAddr_reg    <= awAddr_next;
            wPend_reg     <= wPend_next;
            wData_reg     <= wData_next;
            wStrb_reg     <= wStrb_next;
            bvalid_reg    <= bvalid_next;
            bresp_reg     <= bresp_next;
            rvalid_reg    <= rvalid_next;
            rresp_reg     <= rresp_next;
            rdata_reg     <= rdata_next;
        end
    end

    assign s_axi_awready = !awPend_reg;
    assign s_axi_wready  = !wPend_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = rdata_reg;
    assign frameServe    = serve_reg;
    assign frameForward  = fwd_reg;
    assign chainPorts    = ports_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    wake_ping_base_a: assert property (pingRise |=> !isStack_reg && mode_reg == MODE_ACTIVE)
        else $error("ping wake did not make a base device");
    wake_tone_stack_a: assert property (toneRise && !pingRise |=> isStack_reg && mode_reg == MODE_ACTIVE)
        else $error("tone wake did not make a stack device");
    store_kept_a: assert property (!pingRise && !toneRise |=> $stable(isStack_reg))
        else $error("base or stack flag changed without a wake");
    unaddr_filter_a: assert property (frameValid && mode_reg == MODE_ACTIVE && !addrWr_reg && !pingRise
        && !toneRise && frame.kind != CMD_BCAST_WR |=> !frameServe)
        else $error("unaddressed device served a non broadcast write");
    addressed_single_a: assert property (frameValid && mode_reg == MODE_ADDRESSED && !addrWr_reg && !pingRise
        && !toneRise && frame.kind == CMD_SINGLE_RD && frame.target == ownAddr |=> frameServe)
        else $error("addressed device refused its single read");
    top_tx_off_a: assert property (mode_reg != MODE_POWERED_OFF && topRole_reg && !dirSel_reg
        |=> !chainPorts.upperTx)
        else $error("top device left its upward transmitter on");
    base_unused_off_a: assert property (mode_reg != MODE_POWERED_OFF && !isStack_reg && dirSel_reg
        |=> !chainPorts.upperTx && !chainPorts.upperRx)
        else $error("base device left its unused port on");
    reconfig_hold_a: assert property ($changed(dirSel_reg) |=> (chainPorts == '0) [*3])
        else $error("ports came up during reconfiguration");
    auto_one_frame_a: assert property (autoFrame && !pingRise && !toneRise && !ctlWrite
        |=> !addrWr_reg && !frameForward && frameServe)
        else $error("auto-address frame was relayed or the enable stayed set");
    auto_tx_off_a: assert property (addrWr_reg && !dirSel_reg && !frameValid && !wrFire && !pingRise
        && !toneRise |=> !chainPorts.upperTx)
        else $error("upward transmitter stayed on while the auto-address enable was set");
    auto_store_a: assert property (autoFrame && !pingRise && !toneRise && frame.addrField && !dirSel_reg
        && !wrFire |=> fwdAddr_reg == $past(frame.data))
        else $error("auto address not taken into forward address");
    forward_after_a: assert property (frameValid && !addrWr_reg && mode_reg != MODE_POWERED_OFF && !pingRise
        && !toneRise && outTxOn |=> frameForward)
        else $error("frame was not forwarded up the chain");

    wake_seen_c: cover property (pingRise ##1 mode_reg == MODE_ACTIVE);
    auto_addr_c: cover property (autoFrame ##1 mode_reg == MODE_ADDRESSED);
    stack_read_c: cover property (frameValid && frame.kind == CMD_STACK_RD ##1 frameServe);
    dir_change_c: cover property ($changed(dirSel_reg));
endmodule : chain_bringup
`default_nettype wire

// >>> verification/host_frame_src.sv
`timescale 1ns/100ps
`default_nettype none
module host_frame_src
    import bringup_pkg::*;
(
    // Clock
    input  wire logic clk,
    // Device answers
    input  wire logic frameServe,
    input  wire logic frameForward,
    // Frames towards the device
    output logic      frameValid,
    output cmd_s      frame
);
    initial
    begin
        frameValid = 1'b0;
        frame      = '0;
    end
    // Frames are broadcast writes while addresses are handed out, one unique value per device.
    task automatic send(input cmd_e k, input logic [5:0] t, input logic af, input logic [5:0] d,
                        output logic srv, output logic fwd);
        @(posedge clk);
        frameValid <= 1'b1;
        frame      <= '{kind: k, target: t, addrField: af, data: d};
        @(posedge clk);
        frameValid <= 1'b0;
        // A released bus must not keep showing the last frame.
        frame      <= ~frame;
        #1;
        srv = frameServe;
        fwd = frameForward;
    endtask : send
endmodule : host_frame_src
`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    import bringup_pkg::*;
    logic        clk, rst, awValid, awReady, wValid, wReady, bValid, bReady;
    logic        arValid, arReady, rValid, rReady, ping, toneUp, sdReq, fValid, serve, forward, srv, fwd, toneLow;
    logic [7:0]  awAddr, arAddr;
    logic [31:0] wData, rData, v;
    logic [3:0]  wStrb;
    logic [1:0]  bResp, rResp, r;
    cmd_s        frame;
    chain_port_s ports;
    int          failCount = 0;
    int          totalChecks = 0;
    chain_bringup #(.RECONFIG_CYCLES(8)) i_chain_bringup (.clk(clk), .rst(rst), .s_axi_awaddr(awAddr),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .wakePingPin(ping), .wakeToneUpperPin(toneUp), .wakeToneLowerPin(toneLow), .shutdownReq(sdReq),
        .frameValid(fValid), .frame(frame), .frameServe(serve), .frameForward(forward), .chainPorts(ports));
    host_frame_src i_host_frame_src (.clk(clk), .frameServe(serve), .frameForward(forward),
        .frameValid(fValid), .frame(frame));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", totalChecks, failCount);
        if (failCount == 0 && totalChecks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp)
        begin
            failCount++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {awAddr, wData, awValid, wValid, bReady} <= {a, d, 3'b111};
        for (int i = 0; i < 50; i++)
        begin
            @(posedge clk);
            if (awValid && awReady) awValid <= 1'b0;
            if (wValid && wReady) wValid <= 1'b0;
            if (bValid) begin r = bResp; bReady <= 1'b0; return; end
        end
        failCount++;
        finish_test();
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        {arAddr, arValid, rReady} <= {a, 2'b11};
        for (int i = 0; i < 50; i++)
        begin
            @(posedge clk);
            if (arValid && arReady) arValid <= 1'b0;
            if (rValid) begin {v, r} = {rData, rResp}; rReady <= 1'b0; return; end
        end
        failCount++;
        finish_test();
    endtask : rd
    task automatic fr(input cmd_e k, input logic [5:0] t, input logic af, input logic [5:0] d);
        i_host_frame_src.send(k, t, af, d, srv, fwd);
    endtask : fr
    task automatic test_reset_wake();
        rd(OFFS_STATUS); check("statusReset", v, 32'h0);
        rd(OFFS_FWD_ADDR); check("fwdAddrReset", v, 32'h0);
        rd(8'h14); check("unmappedResp", {30'h0, r}, {30'h0, RESP_SLVERR});
        ping <= 1'b1; repeat (8) @(posedge clk); ping <= 1'b0;
        rd(OFFS_STATUS); check("statusBase", v, 32'h4);
        check("portsBase", {28'h0, ports}, 32'hc);
        // Eight broadcast writes of zero, without an address field, come first after the wake.
        for (int i = 0; i < 8; i++)
        begin
            fr(CMD_BCAST_WR, 6'h0, 1'b0, 6'h0); check("bcastWrEarly", srv, 1'b1);
        end
        fr(CMD_BCAST_RD, 6'h0, 1'b0, 6'h0); check("bcastRdEarly", srv, 1'b0);
        fr(CMD_SINGLE_WR, 6'h0, 1'b0, 6'h0); check("singleWrEarly", srv, 1'b0);
    endtask : test_reset_wake
    task automatic test_autoaddr();
        wr(OFFS_CONTROL, 32'h2); check("ctlWrResp", {30'h0, r}, 32'h0);
        fr(CMD_BCAST_WR, 6'h0, 1'b1, 6'h05); check("ownFrame", {srv, fwd}, 2'b10);
        rd(OFFS_CONTROL); check("enableCleared", v, 32'h0);
        rd(OFFS_FWD_ADDR); check("fwdAddr", v, 32'h5);
        fr(CMD_BCAST_WR, 6'h0, 1'b0, 6'h06); check("nextForwarded", fwd, 1'b1);
        rd(OFFS_STATUS); check("statusAddressed", v, 32'h8);
        fr(CMD_SINGLE_RD, 6'h05, 1'b0, 6'h0); check("singleOwn", srv, 1'b1);
        fr(CMD_SINGLE_RD, 6'h06, 1'b0, 6'h0); check("singleOther", srv, 1'b0);
        fr(CMD_BCAST_RD, 6'h0, 1'b0, 6'h0); check("bcastRd", srv, 1'b1);
    endtask : test_autoaddr
    task automatic test_roles_dir();
        wr(OFFS_ROLE, 32'h0);
        fr(CMD_STACK_WR, 6'h0, 1'b0, 6'h0); check("stackEarly", srv, 1'b0);
        wr(OFFS_ROLE, 32'h3);
        fr(CMD_STACK_RD, 6'h0, 1'b0, 6'h0); check("stackServed", srv, 1'b1);
        check("topUpperTx", ports.upperTx, 1'b0);
        wr(OFFS_CONTROL, 32'h1);
        // The port enables drop one edge after the write lands.
        @(posedge clk);
        check("portsReconfig", {28'h0, ports}, 32'h0);
        repeat (12) @(posedge clk);
        check("portsReverse", {ports.upperTx, ports.upperRx, ports.lowerRx}, 3'b001);
    endtask : test_roles_dir
    task automatic test_stack_wake();
        sdReq <= 1'b1; repeat (2) @(posedge clk); sdReq <= 1'b0;
        toneUp <= 1'b1; repeat (8) @(posedge clk); toneUp <= 1'b0;
        rd(OFFS_STATUS); check("statusStack", v, 32'h5);
        sdReq <= 1'b1; repeat (3) @(posedge clk);
        rd(OFFS_STATUS); check("flagKept", v, 32'h1);
        {sdReq, ping} <= 2'b01; repeat (8) @(posedge clk); ping <= 1'b0;
        rd(OFFS_STATUS); check("rewakeBase", v, 32'h4);
        toneLow <= 1'b1; repeat (8) @(posedge clk); toneLow <= 1'b0;
        rd(OFFS_STATUS); check("lowToneStack", v, 32'h5);
    endtask : test_stack_wake
    initial
    begin
        {rst, awValid, wValid, bReady, arValid, rReady, ping, toneUp, sdReq, toneLow} = 10'h200;
        {awAddr, arAddr, wData, wStrb} = {16'h0, 32'h0, 4'h1};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        test_reset_wake();
        test_autoaddr();
        test_roles_dir();
        test_stack_wake();
        finish_test();
    end
endmodule : tb
`default_nettype wire
